// ==== verilog/mpwmc_core.sv ====
// Six-channel motor PWM control core: counter, buffered values, reload, outputs
// Behaviour
// [R1] Override: fault release checked every clock
// [R2] First enable: reload now, flag, irq
// [R3] Complementary plus sensing: first cycle uses 1,3,5
// [R4] Uncommitted enable: duty zero, modulus kept
// [R5] Dead time never shorter than programmed
// [R6] Enable drives pins from duty values
// [R7] Disable: three-state, counter cleared, outputs zero
// [R8] Disabled: faults, manual pins, dead time live
// [R9] Disable keeps reload flag and irq
// [R10] Clocks run in wait; irq wakes
// [R11] Twelve-bit counter; high read latches low
// [R12] Period: center twice modulus, edge modulus
// [R13] Modulus buffered, adopted on committed reload
// [R14] Modulus unreset; zero counts down from FFF
// [R15] Signed duty: <=0 off, >=modulus on
// [R16] Complementary pairs share duty registers
// [R17] Duty buffered, adopted on committed reload
// [R18] Soft off immediate; release next cycle
// [R19] Reload irq pending while flag and enable
// [R20] Flag set every reload regardless commit
// [R21] Flag cleared by read-then-write zero
// [R22] Flag clear drops reload irq only
// [R23] Commit: read zero, write one; autoclear
// [R24] Reload every 1, 2, 4, 8 cycles
// [R25] Override controls pins while disabled
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none

module mpwmc_core
  import mpwmc_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [DATA_W-1:0] RDATA,
  // Fault pins, active high
  input wire logic [FAULTS-1:0] FAULT_IN,
  // Gate drive pins
  output logic [CHANNELS-1:0] PWM_OUT,
  output logic [CHANNELS-1:0] PWM_OE_N,
  // Interrupt requests, also the wake source in wait
  output logic RELOAD_IRQ,
  output logic FAULT_IRQ
);
  logic rst_meta_ff, rst_n_ff;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end
  // Register decode
  wire wr_ctl1 = WR_STB && (ADDR == A_CTL1);
  wire rd_ctl1 = RD_STB && (ADDR == A_CTL1);
  wire wr_ctl2 = WR_STB && (ADDR == A_CTL2);
  wire rd_cnt_hi = RD_STB && (ADDR == A_CNT_HI);
  wire rd_cnt_lo = RD_STB && (ADDR == A_CNT_LO);
  wire wr_mod_hi = WR_STB && (ADDR == A_MOD_HI);
  wire wr_mod_lo = WR_STB && (ADDR == A_MOD_LO);
  wire wr_dead = WR_STB && (ADDR == A_DEAD);
  wire wr_dmap = WR_STB && (ADDR == A_DMAP);
  wire wr_manual = WR_STB && (ADDR == A_MANUAL);
  wire wr_fstat = WR_STB && (ADDR == A_FSTAT);
  wire wr_fctl = WR_STB && (ADDR == A_FCTL);
  wire in_duty = (ADDR >= A_DUTY_BASE) && (ADDR <= A_DUTY_LAST);
  wire [ADDR_W-1:0] duty_off = ADDR - A_DUTY_BASE;
  wire [2:0] duty_idx = duty_off[3:1];
  // Software state
  logic gen_en_ff, commit_ff, flag_ff, irq_en_ff, softx_ff, softy_ff;
  logic flag_arm_ff, commit_arm_ff;
  logic [DATA_W-1:0] ctl2_ff, dmap_ff, fctl_ff;
  logic [DEAD_W-1:0] dead_ff;
  logic dead_done_ff, dmap_done_ff;
  logic [CHANNELS:0] manual_ff;
  logic [CNT_W-1:0] mod_buf_ff, mod_act_ff;
  logic [DUTY_W-1:0] duty_buf_ff [CHANNELS];
  logic [DUTY_W-1:0] duty_act_ff [CHANNELS];
  // Generator state
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic dir_up_ff, nxt_dir_up;
  logic [DATA_W-1:0] cnt_lo_latch_ff;
  logic cnt_latched_ff;
  logic [2:0] div_cnt_ff;
  logic [1:0] div_act_ff;
  logic [PAIRS-1:0] ipol_act_ff;
  logic first_cycle_ff;
  logic ovr_eff_ff;
  wire center = ctl2_ff[C2_CENTER];
  wire comp = ctl2_ff[C2_COMP];
  wire isense = ctl2_ff[C2_ISENSE];
  wire ovr_req = manual_ff[MAN_OVR];
  wire en_rise = wr_ctl1 && WDATA[C1_EN] && !gen_en_ff;
  wire mod_zero = (mod_act_ff == CNT_ZERO);
  // Counter sequencing
  wire wrap_c = !dir_up_ff && (cnt_ff <= CNT_ONE);
  wire turn_c = dir_up_ff && (cnt_ff >= mod_act_ff);
  wire wrap_e = (cnt_ff >= mod_act_ff);
  wire wrap = gen_en_ff && !mod_zero && (center ? (wrap_c || (turn_c && cnt_ff == CNT_ONE))
                                                : wrap_e);
  wire cyc_start = en_rise || wrap;
  wire [2:0] div_last = 3'((1 << div_act_ff) - 1);
  wire reload = en_rise || (wrap && (div_cnt_ff == div_last)); // [R24] [R2]
  wire release_pt = cyc_start || ovr_eff_ff; // [R1]

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_dir_up = dir_up_ff;
    if (!gen_en_ff || en_rise) begin
      nxt_cnt = en_rise ? (center ? CNT_ZERO : CNT_ONE) : CNT_ZERO; // [R7]
      nxt_dir_up = 1'b1;
    end else if (mod_zero) begin
      nxt_cnt = cnt_ff - CNT_ONE; // [R14]
    end else if (center) begin
      if (wrap) begin
        nxt_cnt = CNT_ZERO; // [R12]
        nxt_dir_up = 1'b1;
      end else if (turn_c) begin
        nxt_cnt = cnt_ff - CNT_ONE;
        nxt_dir_up = 1'b0;
      end else begin
        nxt_cnt = dir_up_ff ? cnt_ff + CNT_ONE : cnt_ff - CNT_ONE;
      end
    end else begin
      nxt_cnt = wrap ? CNT_ONE : cnt_ff + CNT_ONE; // [R12]
    end
  end

  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cnt_ff <= CNT_ZERO;
      dir_up_ff <= 1'b1;
    end else begin
      cnt_ff <= nxt_cnt; // [R11]
      dir_up_ff <= nxt_dir_up;
    end
  end
  // Counter read latch
  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cnt_lo_latch_ff <= '0;
      cnt_latched_ff <= 1'b0;
    end else if (rd_cnt_hi) begin
      cnt_lo_latch_ff <= cnt_ff[7:0]; // [R11]
      cnt_latched_ff <= 1'b1;
    end else if (rd_cnt_lo) begin
      cnt_latched_ff <= 1'b0;
    end
  end
  // Control register one
  wire flag_clear = wr_ctl1 && !WDATA[C1_FLAG] && flag_arm_ff && !reload; // [R21]
  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      gen_en_ff <= 1'b0;
      irq_en_ff <= 1'b0;
      softx_ff <= 1'b0;
      softy_ff <= 1'b0;
      flag_ff <= 1'b0;
      flag_arm_ff <= 1'b0;
      commit_ff <= 1'b0;
      commit_arm_ff <= 1'b0;
    end else begin
      if (wr_ctl1) begin
        gen_en_ff <= WDATA[C1_EN]; // [R9]
        irq_en_ff <= WDATA[C1_IRQEN];
        softx_ff <= WDATA[C1_SOFTX];
        softy_ff <= WDATA[C1_SOFTY];
      end
      // A reload in the same cycle as the clear wins
      if (reload) begin
        flag_ff <= 1'b1; // [R20]
      end else if (flag_clear) begin
        flag_ff <= 1'b0; // [R22]
      end
      if (reload || wr_ctl1) begin
        flag_arm_ff <= 1'b0; // [R21]
      end else if (rd_ctl1 && flag_ff) begin
        flag_arm_ff <= 1'b1;
      end
      if (reload && commit_ff) begin
        commit_ff <= 1'b0; // [R23]
      end else if (wr_ctl1) begin
        commit_ff <= WDATA[C1_COMMIT] ? (commit_ff || commit_arm_ff) : 1'b0; // [R23]
      end
      if (wr_ctl1) begin
        commit_arm_ff <= 1'b0;
      end else if (rd_ctl1 && !commit_ff) begin
        commit_arm_ff <= 1'b1;
      end
    end
  end
  // Other software registers; dead time and map take only their first write
  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ctl2_ff <= CTL2_RESET;
      dmap_ff <= DMAP_RESET;
      dmap_done_ff <= 1'b0;
      dead_ff <= DEAD_RESET;
      dead_done_ff <= 1'b0;
      manual_ff <= '0;
      fctl_ff <= '0;
    end else begin
      if (wr_ctl2) ctl2_ff <= WDATA;
      if (wr_dmap && !dmap_done_ff) begin
        dmap_ff <= WDATA;
        dmap_done_ff <= 1'b1;
      end
      if (wr_dead && !dead_done_ff) begin
        dead_ff <= WDATA;
        dead_done_ff <= 1'b1;
      end
      if (wr_manual) manual_ff <= WDATA[CHANNELS:0];
      if (wr_fctl) fctl_ff <= WDATA;
    end
  end
  // Modulus buffer has no reset on purpose: zero is illegal, so no safe value exists
  always_ff @(posedge CLK) begin
    if (wr_mod_hi) mod_buf_ff[CNT_W-1:8] <= WDATA[3:0]; // [R13] [R14]
    if (wr_mod_lo) mod_buf_ff[7:0] <= WDATA;
    if (reload && commit_ff) mod_act_ff <= mod_buf_ff; // [R13] [R4]
  end
  // Duty buffers and the values in use
  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      for (int i = 0; i < CHANNELS; i++) begin
        duty_buf_ff[i] <= DUTY_RESET;
        duty_act_ff[i] <= DUTY_RESET; // [R4]
      end
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (WR_STB && in_duty && duty_idx == 3'(i)) begin
          if (duty_off[0]) duty_buf_ff[i][7:0] <= WDATA;
          else duty_buf_ff[i][15:8] <= WDATA;
        end
        if (reload && commit_ff) duty_act_ff[i] <= duty_buf_ff[i]; // [R17]
      end
    end
  end
  // Reload divider, first-cycle marker and override hand-back
  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      div_cnt_ff <= DIV_ZERO;
      div_act_ff <= '0;
      ipol_act_ff <= '0;
      first_cycle_ff <= 1'b0;
      ovr_eff_ff <= 1'b0;
    end else begin
      if (reload) begin
        div_cnt_ff <= DIV_ZERO;
        div_act_ff <= ctl2_ff[C2_DIV_LSB+:2]; // [R24]
        ipol_act_ff <= ctl2_ff[C2_IPOL_LSB+:PAIRS];
      end else if (wrap) begin
        div_cnt_ff <= div_cnt_ff + 3'h1;
      end
      if (en_rise) first_cycle_ff <= 1'b1; // [R3]
      else if (wrap) first_cycle_ff <= 1'b0;
      // Leaving override waits for a cycle boundary while enabled, or the next clock while disabled, so no half pulse reaches the pins
      if (ovr_req) ovr_eff_ff <= 1'b1; // [R25]
      else if (cyc_start || !gen_en_ff) ovr_eff_ff <= 1'b0;
    end
  end
  // Duty compare per channel
  wire up_phase = dir_up_ff && (cnt_ff < mod_act_ff);
  logic [CHANNELS-1:0] ch_on;
  for (genvar c = 0; c < CHANNELS; c++) begin : g_cmp
    wire [DUTY_W-1:0] d = duty_act_ff[c];
    wire [DUTY_W-1:0] cnt_x = {4'h0, cnt_ff};
    wire d_pos = !d[DUTY_W-1] && (d != DUTY_RESET);
    wire d_full = d >= {4'h0, mod_act_ff};
    wire d_hit = (center && up_phase) ? (cnt_x < d) : (cnt_x <= d);
    assign ch_on[c] = gen_en_ff && d_pos && (d_full || d_hit); // [R15] [R6] [R7]
  end
  // Pair logic: duty selection and dead time
  logic [CHANNELS-1:0] pin_lvl;
  for (genvar p = 0; p < PAIRS; p++) begin : g_pair
    logic lvl_ff;
    logic [DEAD_W-1:0] dt_ff;
    wire force_odd = isense && first_cycle_ff; // [R3]
    wire use_even = ipol_act_ff[p] && !force_odd;
    wire gen_top = use_even ? ch_on[2*p+1] : ch_on[2*p]; // [R16]
    wire want = ovr_eff_ff ? manual_ff[2*p] : gen_top; // [R8]
    wire quiet = (dt_ff == '0);
    always_ff @(posedge CLK or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
        lvl_ff <= 1'b0;
        dt_ff <= '0;
      end else if (!comp) begin
        lvl_ff <= want;
        dt_ff <= '0;
      end else if (!quiet) begin
        dt_ff <= dt_ff - 8'h01;
        if (dt_ff == 8'h01) lvl_ff <= want;
      end else if (want != lvl_ff) begin
        // Loaded from the live count at each edge, so a late change never shortens it
        if (dead_ff == '0) lvl_ff <= want;
        else dt_ff <= dead_ff; // [R5] [R8]
      end
    end
    wire bot_gen = ovr_eff_ff ? manual_ff[2*p+1] : 1'b1;
    wire ind_bot = ovr_eff_ff ? manual_ff[2*p+1] : ch_on[2*p+1];
    assign pin_lvl[2*p] = comp ? (lvl_ff && quiet) : want;
    assign pin_lvl[2*p+1] = comp ? (!lvl_ff && quiet && bot_gen && (gen_en_ff || ovr_eff_ff))
                                 : ind_bot;
  end
  // Faults and bank disables
  logic [FAULTS-1:0] flt_prev_ff, flt_flag_ff, flt_hold_ff;
  logic bankx_hold_ff, banky_hold_ff;
  wire [FAULTS-1:0] flt_rise = FAULT_IN & ~flt_prev_ff;
  wire [FAULTS-1:0] flt_ack = wr_fstat ? WDATA[FAULTS-1:0] : '0;
  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      flt_prev_ff <= '0;
      flt_flag_ff <= '0;
      flt_hold_ff <= '0;
      bankx_hold_ff <= 1'b0;
      banky_hold_ff <= 1'b0;
    end else begin
      flt_prev_ff <= FAULT_IN;
      flt_flag_ff <= flt_rise | (flt_flag_ff & ~flt_ack);
      for (int f = 0; f < FAULTS; f++) begin
        if (FAULT_IN[f]) flt_hold_ff[f] <= 1'b1;
        else if (release_pt && !flt_flag_ff[f]) flt_hold_ff[f] <= 1'b0; // [R1] [R8]
      end
      if (softx_ff) bankx_hold_ff <= 1'b1; // [R18]
      else if (release_pt) bankx_hold_ff <= 1'b0;
      if (softy_ff) banky_hold_ff <= 1'b1; // [R18]
      else if (release_pt) banky_hold_ff <= 1'b0;
    end
  end
  wire dis_x = bankx_hold_ff || softx_ff || (|flt_hold_ff[1:0]) || (|FAULT_IN[1:0]);
  wire dis_y = banky_hold_ff || softy_ff || (|flt_hold_ff[3:2]) || (|FAULT_IN[3:2]);
  logic [CHANNELS-1:0] pin_off;
  for (genvar p = 0; p < PAIRS; p++) begin : g_map
    wire off = (dis_x && dmap_ff[p]) || (dis_y && dmap_ff[PAIRS+p]);
    assign pin_off[2*p] = off;
    assign pin_off[2*p+1] = off;
  end
  // Read mux
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (in_duty) begin
      rd_mux = duty_off[0] ? duty_buf_ff[duty_idx][7:0] : duty_buf_ff[duty_idx][15:8];
    end else begin
      unique case (ADDR)
        A_CTL1: begin
          rd_mux[C1_EN] = gen_en_ff;
          rd_mux[C1_COMMIT] = commit_ff;
          rd_mux[C1_FLAG] = flag_ff;
          rd_mux[C1_IRQEN] = irq_en_ff;
          rd_mux[C1_SOFTX] = softx_ff;
          rd_mux[C1_SOFTY] = softy_ff;
        end
        A_CTL2: rd_mux = ctl2_ff;
        A_CNT_HI: rd_mux = {4'h0, cnt_ff[CNT_W-1:8]};
        A_CNT_LO: rd_mux = cnt_latched_ff ? cnt_lo_latch_ff : cnt_ff[7:0]; // [R11]
        A_MOD_HI: rd_mux = {4'h0, mod_buf_ff[CNT_W-1:8]}; // [R13]
        A_MOD_LO: rd_mux = mod_buf_ff[7:0];
        A_DEAD: rd_mux = dead_ff;
        A_DMAP: rd_mux = dmap_ff;
        A_MANUAL: rd_mux = {1'b0, manual_ff};
        A_FSTAT: rd_mux = {FAULT_IN, flt_flag_ff};
        A_FCTL: rd_mux = fctl_ff;
        default: rd_mux = '0;
      endcase
    end
  end
  // Registered outputs
  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      RDATA <= '0;
      PWM_OUT <= '0;
      PWM_OE_N <= '1;
      RELOAD_IRQ <= 1'b0;
      FAULT_IRQ <= 1'b0;
    end else begin
      RDATA <= RD_STB ? rd_mux : '0;
      PWM_OUT <= pin_lvl & ~pin_off; // [R6]
      PWM_OE_N <= {CHANNELS{!(gen_en_ff || ovr_req)}}; // [R7] [R25]
      RELOAD_IRQ <= flag_ff && irq_en_ff && !flag_clear; // [R19] [R10]
      FAULT_IRQ <= |(flt_flag_ff & fctl_ff[FAULTS-1:0]); // [R22] [R10]
    end
  end

endmodule

`default_nettype wire

// ==== include/mpwmc_pkg.sv ====
// Register map, field positions and reset values of the motor PWM control core
package mpwmc_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int CNT_W = 12;
  localparam int DUTY_W = 16;
  localparam int CHANNELS = 6;
  localparam int PAIRS = 3;
  localparam int FAULTS = 4;
  localparam int DEAD_W = 8;

  localparam logic [ADDR_W-1:0] A_CTL1 = 5'h00;
  localparam logic [ADDR_W-1:0] A_CTL2 = 5'h01;
  localparam logic [ADDR_W-1:0] A_CNT_HI = 5'h02;
  localparam logic [ADDR_W-1:0] A_CNT_LO = 5'h03;
  localparam logic [ADDR_W-1:0] A_MOD_HI = 5'h04;
  localparam logic [ADDR_W-1:0] A_MOD_LO = 5'h05;
  localparam logic [ADDR_W-1:0] A_DEAD = 5'h06;
  localparam logic [ADDR_W-1:0] A_DMAP = 5'h07;
  localparam logic [ADDR_W-1:0] A_MANUAL = 5'h08;
  localparam logic [ADDR_W-1:0] A_FSTAT = 5'h09;
  localparam logic [ADDR_W-1:0] A_FCTL = 5'h0a;
  localparam logic [ADDR_W-1:0] A_DUTY_BASE = 5'h10;
  localparam logic [ADDR_W-1:0] A_DUTY_LAST = 5'h1b;

  // generator_control_one
  localparam int C1_EN = 0;
  localparam int C1_COMMIT = 1;
  localparam int C1_FLAG = 4;
  localparam int C1_IRQEN = 5;
  localparam int C1_SOFTX = 6;
  localparam int C1_SOFTY = 7;
  // generator_control_two
  localparam int C2_DIV_LSB = 0;
  localparam int C2_CENTER = 2;
  localparam int C2_COMP = 3;
  localparam int C2_ISENSE = 4;
  localparam int C2_IPOL_LSB = 5;
  // manual_output_register
  localparam int MAN_OVR = 6;

  localparam logic [DATA_W-1:0] CTL2_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DMAP_RESET = 8'hff;
  localparam logic [DEAD_W-1:0] DEAD_RESET = 8'h00;
  localparam logic [DUTY_W-1:0] DUTY_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
  localparam logic [2:0] DIV_ZERO = 3'h0;

endpackage

// ==== verif/mpwmc_core_asserts.sv ====
// Port-level assertions for the motor PWM control core
`timescale 1ns/100ps
`default_nettype none
module mpwmc_core_chk
  import mpwmc_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [DATA_W-1:0] RDATA,
  // Pins and requests
  input wire logic [FAULTS-1:0] FAULT_IN,
  input wire logic [CHANNELS-1:0] PWM_OUT,
  input wire logic [CHANNELS-1:0] PWM_OE_N,
  input wire logic RELOAD_IRQ,
  input wire logic FAULT_IRQ
);
  // Shadows of written bits, so no read-back is needed
  logic en_ff;
  logic ovr_ff;
  logic mv_ff;
  logic [7:0] mlo_ff;
  logic [3:0] fen_ff;
  wire c1_wr = WR_STB && ADDR == A_CTL1;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      en_ff <= 1'b0;
      ovr_ff <= 1'b0;
      mv_ff <= 1'b0;
      mlo_ff <= 8'h00;
      fen_ff <= 4'h0;
    end else if (WR_STB) begin
      if (ADDR == A_CTL1) en_ff <= WDATA[C1_EN];
      if (ADDR == A_MANUAL) ovr_ff <= WDATA[MAN_OVR];
      if (ADDR == A_FCTL) fen_ff <= WDATA[3:0];
      if (ADDR == A_MOD_LO) mv_ff <= 1'b1;
      if (ADDR == A_MOD_LO) mlo_ff <= WDATA;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence en_rise_s;
    c1_wr && WDATA[C1_EN] && !en_ff;
  endsequence
  sequence irq_start_s;
    en_rise_s ##0 WDATA[C1_IRQEN];
  endsequence
  oe_on_a: assert property (en_rise_s |-> ##2 PWM_OE_N == 6'h00)
    else $error("pins not driven after enable");
  oe_off_a: assert property (c1_wr && !WDATA[C1_EN] && !ovr_ff |-> ##2 PWM_OE_N == 6'h3f)
    else $error("pins not released after disable");
  out_zero_a: assert property ((!en_ff && !ovr_ff)[*3] |-> PWM_OUT == 6'h00)
    else $error("outputs active while disabled");
  ovr_pins_a: assert property (ovr_ff[*3] |-> PWM_OE_N == 6'h00)
    else $error("override lost the pins");
  first_irq_a: assert property (irq_start_s |-> ##[1:2] RELOAD_IRQ)
    else $error("no reload request on enable");
  irq_mask_a: assert property (c1_wr && !WDATA[C1_IRQEN] |-> ##[1:2] !RELOAD_IRQ)
    else $error("reload request not inhibited");
  irq_keep_a: assert property (c1_wr && !WDATA[C1_EN] && WDATA[C1_IRQEN] && WDATA[C1_FLAG]
    && RELOAD_IRQ |=> RELOAD_IRQ[*2])
    else $error("disable dropped reload request");
  fault_keep_a: assert property (c1_wr && !WDATA[C1_FLAG] && FAULT_IRQ |=> FAULT_IRQ)
    else $error("flag clear dropped fault request");
  fault_off_a: assert property (fen_ff == 4'h0 && $past(fen_ff) == 4'h0 |-> !FAULT_IRQ)
    else $error("fault request while not enabled");
  mod_read_a: assert property (RD_STB && ADDR == A_MOD_LO && mv_ff |=> RDATA == mlo_ff)
    else $error("modulus read is not the buffer");
endmodule
`default_nettype wire

// ==== verif/mpwmc_stage.sv ====
// Gate-drive stage model: overcurrent sense that raises fault pin 0
`timescale 1ns/100ps
`default_nettype none
module mpwmc_stage
  import mpwmc_pkg::*;
(
  // Clock
  input wire logic CLK,
  // Overcurrent request from the bench
  input wire logic trip,
  // Fault pins to the core
  output logic [FAULTS-1:0] FAULT_IN
);
  logic trip_ff = 1'b0;
  // Sense comparator output is registered, as a real one lags the current
  always @(posedge CLK) trip_ff <= trip;
  assign FAULT_IN = {3'b000, trip_ff};
endmodule
`default_nettype wire

// ==== verif/motor_pwm_control_core_bench.sv ====
// Self-checking bench for the motor PWM control core
`timescale 1ns/100ps
`default_nettype none
module motor_pwm_control_core_bench
  import mpwmc_pkg::*;
;
  localparam int M = 20;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic [ADDR_W-1:0] ADDR = 5'h00;
  logic [DATA_W-1:0] WDATA = 8'h00;
  logic WR_STB = 1'b0;
  logic RD_STB = 1'b0;
  logic trip = 1'b0;
  wire [DATA_W-1:0] RDATA;
  wire [FAULTS-1:0] FAULT_IN;
  wire [CHANNELS-1:0] PWM_OUT;
  wire [CHANNELS-1:0] PWM_OE_N;
  wire RELOAD_IRQ;
  wire FAULT_IRQ;
  int n_errors = 0;
  int n_compared = 0;
  int mdl [32];
  int cyc = 0;
  int ta;
  int tb;
  int ones;
  logic [7:0] rv;
  logic [5:0] lv;
  logic [5:0] acc_or;
  logic [5:0] acc_and;
  always #5 CLK = ~CLK;
  always @(posedge CLK) cyc <= cyc + 1;
  mpwmc_core i_dut (.CLK, .NRST, .ADDR, .WDATA, .WR_STB, .RD_STB, .RDATA,
    .FAULT_IN, .PWM_OUT, .PWM_OE_N, .RELOAD_IRQ, .FAULT_IRQ);
  mpwmc_stage i_stage (.CLK, .trip, .FAULT_IN);
  task automatic wrap_up;
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_cnt(input int g, input int e);
    n_compared++;
    if (g != e) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    ADDR <= a;
    WDATA <= d;
    WR_STB <= 1'b1;
    mdl[a] = d;
    @(posedge CLK);
    WR_STB <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rd(input logic [4:0] a);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CLK);
    RD_STB <= 1'b0;
    @(negedge CLK);
    rv = RDATA;
    @(posedge CLK);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    rd(a);
    chk_reg(rv, e);
  endtask
  // Looks at reload, fault request and outputs mid-cycle, away from edges
  task automatic pins(input logic [7:0] m, input logic [7:0] e);
    @(negedge CLK);
    chk_reg({RELOAD_IRQ, FAULT_IRQ, PWM_OUT} & m, e);
    @(posedge CLK);
  endtask
  task automatic wait_irq(output int t);
    int k;
    k = 0;
    @(negedge CLK);
    while (RELOAD_IRQ !== 1'b1) begin
      k++;
      if (k > 3000) begin
        n_errors++;
        wrap_up();
      end
      @(negedge CLK);
    end
    t = cyc;
    @(posedge CLK);
  endtask
  task automatic clr;
    rd(A_CTL1);
    wr(A_CTL1, 8'h21);
  endtask
  // First interval may still run on old settings, so time the second
  task automatic period(input int e);
    wait_irq(ta);
    clr();
    wait_irq(ta);
    clr();
    wait_irq(tb);
    clr();
    chk_cnt(tb - ta, e);
  endtask
  task automatic fault;
    trip <= 1'b1;
    repeat (4) @(posedge CLK);
  endtask
  task automatic unfault;
    trip <= 1'b0;
    repeat (3) @(posedge CLK);
    wr(A_FSTAT, 8'hff);
  endtask
  initial begin
    void'($urandom(32'h4fb46356));
    repeat (16) @(posedge CLK);
    NRST <= 1'b1;
    repeat (3) @(posedge CLK);
    rdc(A_CTL2, CTL2_RESET);
    rdc(A_DMAP, DMAP_RESET);
    rdc(A_DEAD, DEAD_RESET);
    lv = 6'($urandom);
    wr(A_DEAD, {2'b00, lv});
    wr(A_DEAD, 8'hff);
    rdc(A_DEAD, {2'b00, lv});
    wr(5'h0c, 8'h5a);
    rdc(5'h0c, 8'h00);
    for (int a = 16; a < 28; a++) wr(5'(a), 8'($urandom));
    wr(A_MOD_HI, 8'h00);
    wr(A_MOD_LO, 8'(M));
    for (int a = 16; a < 28; a++) rdc(5'(a), 8'(mdl[a]));
    rdc(A_MOD_HI, 8'h00);
    rdc(A_MOD_LO, 8'(M));
    wr(5'h10, 8'hff);
    wr(5'h11, 8'hf0);
    wr(5'h12, 8'h00);
    wr(5'h13, 8'(M));
    wr(5'h14, 8'h00);
    wr(5'h15, 8'(M / 2));
    rdc(A_CTL1, 8'h00);
    wr(A_CTL1, 8'h02);
    rdc(A_CTL1, 8'h02);
    wr(A_CTL1, 8'h23);
    rdc(A_CTL1, 8'h31);
    for (int c = 0; c < 2; c++) begin
      for (int d = 0; d < 4; d++) begin
        wr(A_CTL2, 8'(c * 4 + d));
        period(M * (c + 1) << d);
      end
    end
    wr(A_CTL2, 8'h00);
    period(M);
    acc_or = 6'h00;
    acc_and = 6'h3f;
    ones = 0;
    repeat (2 * M) begin
      @(negedge CLK);
      acc_or = acc_or | PWM_OUT;
      acc_and = acc_and & PWM_OUT;
      ones += int'(PWM_OUT[2]);
    end
    @(posedge CLK);
    chk_reg({6'h00, acc_or[0], acc_and[1]}, 8'h01);
    chk_cnt(ones, M);
    rdc(A_CNT_HI, 8'h00);
    rd(A_CNT_LO);
    ta = int'(rv);
    rd(A_CNT_LO);
    chk_cnt(int'(rv), (ta + 3) % M + 1);
    wr(A_CTL1, 8'h71);
    pins(8'h02, 8'h00);
    period(M);
    pins(8'h02, 8'h02);
    wr(A_FCTL, 8'h01);
    fault();
    pins(8'h42, 8'h40);
    clr();
    pins(8'h40, 8'h40);
    unfault();
    period(M);
    pins(8'h42, 8'h02);
    wait_irq(ta);
    wr(A_CTL1, 8'h30);
    pins(8'h80, 8'h80);
    @(negedge CLK);
    chk_reg({2'b00, PWM_OE_N}, 8'h3f);
    @(posedge CLK);
    rdc(A_CNT_HI, 8'h00);
    repeat (5) @(posedge CLK);
    rdc(A_CNT_LO, 8'h00);
    lv = 6'($urandom) | 6'h02;
    wr(A_MANUAL, {2'b01, lv});
    // Override reaches the pins through one more flop than the pin data
    @(posedge CLK);
    pins(8'h3f, {2'b00, lv});
    wr(A_FCTL, 8'h00);
    fault();
    pins(8'h7f, 8'h00);
    unfault();
    // Fault hold drops one clock after the acknowledge
    @(posedge CLK);
    pins(8'h3f, {2'b00, lv});
    wr(A_MANUAL, 8'h00);
    wr(A_CTL1, 8'h21);
    period(M);
    wr(A_CTL2, 8'h08);
    period(M);
    acc_or = 6'h00;
    acc_and = 6'h3f;
    repeat (2 * M) begin
      @(negedge CLK);
      acc_or[0] = acc_or[0] | (PWM_OUT[2] & PWM_OUT[3]);
      acc_and = acc_and & PWM_OUT;
    end
    @(posedge CLK);
    chk_reg({6'h00, acc_or[0], acc_and[1]}, 8'h01);
    wait_irq(ta);
    wr(A_CTL1, 8'h11);
    pins(8'h80, 8'h00);
    rdc(A_CTL1, 8'h11);
    wrap_up();
  end
endmodule
bind mpwmc_core mpwmc_core_chk i_chk (.CLK, .NRST, .ADDR, .WDATA, .WR_STB, .RD_STB, .RDATA,
  .FAULT_IN, .PWM_OUT, .PWM_OE_N, .RELOAD_IRQ, .FAULT_IRQ);
`default_nettype wire
